// >>> design/dac_core.sv
`timescale 1ns/100ps

// Overview of operation
// - Short address accepts 1 to 127 and is matched when short format selected.
// - Long address 1 to 9999 held across two variables as alternative.
// - Long-address variables change only through the paired write sequence.
// - Short and long addresses change only in service mode.
// - Config bit 4 enables the speed table chosen by table-select.
// - Config bit 1 set gives 28 or 128 steps; clear gives 14.
// - Config bit 0 set inverts received direction commands.
// - Throttle range is split into 14, 28 or 128 discrete steps.
// - Config bits act independently; one write enables all chosen options.
// - Operations-mode writes to address variables are refused.
// - Each variable is one byte wide; only table-select and the low long-address byte take any value 0 to 255.
module dac_core
   import dac_pkg::*;
(
   input  wire logic           i_clock,
   input  wire logic           i_nrst,
   input  wire dac_cv_req_t    i_cv_req,
   input  wire dac_pkt_t       i_pkt,
   output logic                o_cv_ack,
   output logic                o_cv_err,
   output logic [7:0]          o_cv_rdata,
   output logic                o_long_pending,
   output logic                o_pkt_hit,
   output logic [6:0]          o_speed_step,
   output logic                o_dir_fwd,
   output dac_step_mode_t      o_step_mode,
   output logic                o_table_en,
   output logic [7:0]          o_table_sel,
   output logic                o_long_sel
);

   // Whole state of the block
   typedef struct packed {
      logic [7:0]     short_addr;
      logic [7:0]     long_hi;
      logic [7:0]     long_lo;
      logic [7:0]     table_sel;
      logic [7:0]     cfg;
      logic           pend_v;
      logic [7:0]     pend_hi;
      logic           ack;
      logic           err;
      logic [7:0]     rdata;
      logic           hit;
      logic [6:0]     step;
      logic           fwd;
      dac_step_mode_t mode;
   } dac_state_t;

   dac_state_t s_q;
   dac_state_t s_d;

   logic [6:0]     map_step;
   logic           map_fwd;
   dac_step_mode_t map_mode;
   logic [13:0]    long_cur;
   logic [13:0]    long_new;
   logic           short_ok;
   logic           long_ok;
   logic           addr_cv;
   logic           addr_hit;

   // Speed and direction translation for the incoming packet
   dac_speed_map u_map (
      .i_cfg   (s_q.cfg),
      .i_fine  (i_pkt.fine),
      .i_fwd   (i_pkt.fwd),
      .i_speed (i_pkt.speed),
      .o_step  (map_step),
      .o_fwd   (map_fwd),
      .o_mode  (map_mode)
   );

   // Address values and their range checks
   assign long_cur = {s_q.long_hi[5:0], s_q.long_lo};
   assign long_new = {s_q.pend_hi[5:0], i_cv_req.data};
   assign short_ok = (i_cv_req.data >= DAC_SHORT_MIN)
                   && (i_cv_req.data <= DAC_SHORT_MAX);
   assign long_ok  = (long_new >= DAC_LONG_MIN) && (long_new <= DAC_LONG_MAX);
   assign addr_cv  = (i_cv_req.num == DAC_CV_SHORT_ADDR)
                   || (i_cv_req.num == DAC_CV_LONG_HI)
                   || (i_cv_req.num == DAC_CV_LONG_LO);

   // Address match selected by the format bit
   always_comb begin
      if (s_q.cfg[DAC_BIT_LONG_ADDR]) begin
         addr_hit = i_pkt.long_fmt && (i_pkt.addr == long_cur);
      end else begin
         addr_hit = !i_pkt.long_fmt
                  && (i_pkt.addr == {6'h00, s_q.short_addr});
      end
   end

   // Next-state logic
   always_comb begin
      s_d       = s_q;
      s_d.ack   = 1'b0;
      s_d.err   = 1'b0;
      s_d.hit   = 1'b0;

      // Programming requests
      if (i_cv_req.valid && i_cv_req.write) begin
         s_d.ack = 1'b1;
         // Any write other than the low byte ends a pending sequence
         if (i_cv_req.num != DAC_CV_LONG_LO) begin
            s_d.pend_v = 1'b0;
         end
         if (addr_cv && !i_cv_req.service) begin
            s_d.err    = 1'b1;
            s_d.pend_v = 1'b0;
         end else if (i_cv_req.num == DAC_CV_SHORT_ADDR) begin
            if (short_ok) begin
               s_d.short_addr = i_cv_req.data;
            end else begin
               s_d.err = 1'b1;
            end
         end else if (i_cv_req.num == DAC_CV_LONG_HI) begin
            // First half is only held, not yet applied
            if (i_cv_req.data[7:6] == DAC_LONG_MARK) begin
               s_d.pend_v  = 1'b1;
               s_d.pend_hi = i_cv_req.data;
            end else begin
               s_d.err = 1'b1;
            end
         end else if (i_cv_req.num == DAC_CV_LONG_LO) begin
            // Second half commits both bytes together
            s_d.pend_v = 1'b0;
            if (s_q.pend_v && long_ok) begin
               s_d.long_hi = s_q.pend_hi;
               s_d.long_lo = i_cv_req.data;
            end else begin
               s_d.err = 1'b1;
            end
         end else if (i_cv_req.num == DAC_CV_TABLE_SEL) begin
            s_d.table_sel = i_cv_req.data;
         end else if (i_cv_req.num == DAC_CV_CONFIG) begin
            s_d.cfg = i_cv_req.data & DAC_CFG_MASK;
         end else begin
            s_d.err = 1'b1;
         end
      end else if (i_cv_req.valid) begin
         // Reads return the stored byte
         s_d.ack = 1'b1;
         if (i_cv_req.num == DAC_CV_SHORT_ADDR) begin
            s_d.rdata = s_q.short_addr;
         end else if (i_cv_req.num == DAC_CV_LONG_HI) begin
            s_d.rdata = s_q.long_hi;
         end else if (i_cv_req.num == DAC_CV_LONG_LO) begin
            s_d.rdata = s_q.long_lo;
         end else if (i_cv_req.num == DAC_CV_TABLE_SEL) begin
            s_d.rdata = s_q.table_sel;
         end else if (i_cv_req.num == DAC_CV_CONFIG) begin
            s_d.rdata = s_q.cfg;
         end else begin
            s_d.rdata = 8'h00;
            s_d.err   = 1'b1;
         end
      end

      // Speed packets addressed to us
      if (i_pkt.valid && addr_hit) begin
         s_d.hit  = 1'b1;
         s_d.step = map_step;
         s_d.fwd  = map_fwd;
         s_d.mode = map_mode;
      end else if (i_cv_req.valid && i_cv_req.write && (i_cv_req.num == DAC_CV_CONFIG)) begin
         // Mode follows a configuration write unless a speed packet for us arrives in the same cycle
         s_d.mode = s_d.cfg[DAC_BIT_FINE_STEPS] ? DAC_MODE_28 : DAC_MODE_14;
      end
   end

   // State register
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         s_q.short_addr <= DAC_RST_SHORT;
         s_q.long_hi    <= DAC_RST_LONG_HI;
         s_q.long_lo    <= DAC_RST_LONG_LO;
         s_q.table_sel  <= DAC_RST_TABLE;
         s_q.cfg        <= DAC_RST_CONFIG;
         s_q.pend_v     <= 1'b0;
         s_q.pend_hi    <= 8'h00;
         s_q.ack        <= 1'b0;
         s_q.err        <= 1'b0;
         s_q.rdata      <= 8'h00;
         s_q.hit        <= 1'b0;
         s_q.step       <= 7'h00;
         s_q.fwd        <= 1'b1;
         s_q.mode       <= DAC_MODE_14;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign o_cv_ack       = s_q.ack;
   assign o_cv_err       = s_q.err;
   assign o_cv_rdata     = s_q.rdata;
   assign o_long_pending = s_q.pend_v;
   assign o_pkt_hit      = s_q.hit;
   assign o_speed_step   = s_q.step;
   assign o_dir_fwd      = s_q.fwd;
   assign o_step_mode    = s_q.mode;
   assign o_table_en     = s_q.cfg[DAC_BIT_TABLE_EN];
   assign o_table_sel    = s_q.table_sel;
   assign o_long_sel     = s_q.cfg[DAC_BIT_LONG_ADDR];

endmodule : dac_core

// >>> design/dac_pkg.sv
package dac_pkg;

   // Configuration variable numbers
   localparam logic [9:0] DAC_CV_SHORT_ADDR = 10'h001;
   localparam logic [9:0] DAC_CV_LONG_HI    = 10'h011;
   localparam logic [9:0] DAC_CV_LONG_LO    = 10'h012;
   localparam logic [9:0] DAC_CV_TABLE_SEL  = 10'h019;
   localparam logic [9:0] DAC_CV_CONFIG     = 10'h01d;

   // Configuration byte bit positions
   localparam int DAC_BIT_DIR_INV    = 0;
   localparam int DAC_BIT_FINE_STEPS = 1;
   localparam int DAC_BIT_TABLE_EN   = 4;
   localparam int DAC_BIT_LONG_ADDR  = 5;

   // Only the four option bits are kept
   localparam logic [7:0] DAC_CFG_MASK = 8'h33;

   // Reset values after power-up
   localparam logic [7:0] DAC_RST_SHORT   = 8'h03;
   localparam logic [7:0] DAC_RST_LONG_HI = 8'hc0;
   localparam logic [7:0] DAC_RST_LONG_LO = 8'h00;
   localparam logic [7:0] DAC_RST_TABLE   = 8'h00;
   localparam logic [7:0] DAC_RST_CONFIG  = 8'h00;

   // Legal address ranges
   localparam logic [7:0]  DAC_SHORT_MIN = 8'h01;
   localparam logic [7:0]  DAC_SHORT_MAX = 8'h7f;
   localparam logic [13:0] DAC_LONG_MIN  = 14'h0001;
   localparam logic [13:0] DAC_LONG_MAX  = 14'h270f;

   // High long-address byte carries this marker in its top two bits
   localparam logic [1:0]  DAC_LONG_MARK = 2'h3;

   // Speed step ceilings
   localparam logic [6:0] DAC_STEPS_14  = 7'h0e;
   localparam logic [6:0] DAC_STEPS_28  = 7'h1c;
   localparam logic [6:0] DAC_STEPS_128 = 7'h7f;

   // Speed step mode reported to the motor logic
   typedef enum logic [1:0] {
      DAC_MODE_14,
      DAC_MODE_28,
      DAC_MODE_128
   } dac_step_mode_t;

   // Programming request from the packet decoder
   typedef struct packed {
      logic       valid;
      logic       write;
      logic       service;
      logic [9:0] num;
      logic [7:0] data;
   } dac_cv_req_t;

   // Decoded speed and direction packet
   typedef struct packed {
      logic        valid;
      logic        long_fmt;
      logic [13:0] addr;
      logic        fine;
      logic        fwd;
      logic [6:0]  speed;
   } dac_pkt_t;

endpackage : dac_pkg

// >>> design/dac_speed_map.sv
`timescale 1ns/100ps

module dac_speed_map
   import dac_pkg::*;
(
   input  wire logic [7:0] i_cfg,
   input  wire logic       i_fine,
   input  wire logic       i_fwd,
   input  wire logic [6:0] i_speed,
   output logic [6:0]      o_step,
   output logic            o_fwd,
   output dac_step_mode_t  o_mode
);

   // Clamp the commanded speed to the active step range
   always_comb begin
      if (!i_cfg[DAC_BIT_FINE_STEPS]) begin
         o_mode = DAC_MODE_14;
         o_step = (i_speed > DAC_STEPS_14) ? DAC_STEPS_14 : i_speed;
      end else if (i_fine) begin
         o_mode = DAC_MODE_128;
         o_step = (i_speed > DAC_STEPS_128) ? DAC_STEPS_128 : i_speed;
      end else begin
         o_mode = DAC_MODE_28;
         o_step = (i_speed > DAC_STEPS_28) ? DAC_STEPS_28 : i_speed;
      end
   end

   // Direction inversion
   assign o_fwd = i_fwd ^ i_cfg[DAC_BIT_DIR_INV];

endmodule : dac_speed_map

// >>> verification/dac_core_properties.sv
`timescale 1ns/100ps
module dac_core_props
   import dac_pkg::*;
(
   input  wire logic           i_clock,
   input  wire logic           i_nrst,
   input  wire dac_cv_req_t    i_cv_req,
   input  wire logic           o_cv_err,
   input  wire logic [7:0]     o_cv_rdata,
   input  wire logic           o_long_pending,
   input  wire logic           o_pkt_hit,
   input  wire logic [6:0]     o_speed_step,
   input  wire dac_step_mode_t o_step_mode,
   input  wire logic           o_table_en,
   input  wire logic           o_long_sel
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   logic       wr, cfg_wr, cfg_rd, addr_var, short_bad, hi_ok;
   logic [6:0] lim;
   // Request qualifiers and step ceiling
   assign wr        = i_cv_req.valid && i_cv_req.write;
   assign cfg_wr    = wr && (i_cv_req.num == DAC_CV_CONFIG);
   assign cfg_rd    = i_cv_req.valid && !i_cv_req.write && (i_cv_req.num == DAC_CV_CONFIG);
   assign addr_var  = i_cv_req.num inside {DAC_CV_SHORT_ADDR, DAC_CV_LONG_HI, DAC_CV_LONG_LO};
   assign short_bad = !(i_cv_req.data inside {[DAC_SHORT_MIN:DAC_SHORT_MAX]});
   assign hi_ok     = i_cv_req.service && (i_cv_req.data[7:6] == DAC_LONG_MARK);
   assign lim       = (o_step_mode == DAC_MODE_14) ? DAC_STEPS_14 :
                      (o_step_mode == DAC_MODE_28) ? DAC_STEPS_28 : DAC_STEPS_128;
   a_ops_addr_refused: assert property (wr && !i_cv_req.service && addr_var |=> o_cv_err)
      else $error("ops address write taken");
   a_short_range: assert property (wr && i_cv_req.num == DAC_CV_SHORT_ADDR && short_bad |=> o_cv_err)
      else $error("bad short address taken");
   a_cfg_unused_zero: assert property (cfg_rd |=> (o_cv_rdata & ~DAC_CFG_MASK) == 8'h00)
      else $error("unused config bits set");
   a_table_en_bit: assert property (cfg_wr |=> o_table_en == $past(i_cv_req.data[4]))
      else $error("table enable wrong");
   a_long_sel_bit: assert property (cfg_wr |=> o_long_sel == $past(i_cv_req.data[5]))
      else $error("long select wrong");
   a_mode_follows: assert property (cfg_wr |=>
      o_step_mode == ($past(i_cv_req.data[1]) ? DAC_MODE_28 : DAC_MODE_14))
      else $error("step mode wrong");
   a_step_ceiling: assert property (o_pkt_hit |-> o_speed_step <= lim)
      else $error("step above ceiling");
   a_long_pending_set: assert property (wr && i_cv_req.num == DAC_CV_LONG_HI && hi_ok ##1 1'b1
      |-> o_long_pending) else $error("pending not set");
endmodule : dac_core_props

// >>> verification/dac_core_tb.sv
`timescale 1ns/100ps
module dac_core_tb
   import dac_pkg::*;
;
   logic           i_clock = 1'b0;
   logic           i_nrst, ack, err, pend, hit, dir, ten, lsel, a, e, h;
   dac_cv_req_t    cv_req;
   dac_pkt_t       pkt;
   logic [7:0]     rdata, tsel, r;
   logic [6:0]     step;
   dac_step_mode_t mode;
   int             fails, comparisons, cycles;
   logic [7:0]     cfgs [6] = '{8'h00, 8'h10, 8'h02, 8'h01, 8'h20, 8'hff};
   dac_core u_dac_core (.i_clock(i_clock), .i_nrst(i_nrst), .i_cv_req(cv_req), .i_pkt(pkt),
      .o_cv_ack(ack), .o_cv_err(err), .o_cv_rdata(rdata), .o_long_pending(pend),
      .o_pkt_hit(hit), .o_speed_step(step), .o_dir_fwd(dir), .o_step_mode(mode),
      .o_table_en(ten), .o_table_sel(tsel), .o_long_sel(lsel));
   dac_station u_dac_station (.i_clock(i_clock), .i_cv_ack(ack), .i_cv_err(err),
      .i_cv_rdata(rdata), .i_pkt_hit(hit), .o_cv_req(cv_req), .o_pkt(pkt));
   // Clock and hang guard
   always #20 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         end_sim();
      end
   end
   task automatic chk(input logic [13:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Access with expected answer
   task automatic acc(input logic w, s, input logic [9:0] n, input logic [7:0] d,
                      input logic xe, input logic [7:0] xr);
      u_dac_station.cv(w, s, n, d, a, e, r);
      chk(a, 1'b1);
      chk(e, xe);
      if (!w) begin
         chk(r, xr);
      end
   endtask : acc
   task automatic go(input logic lf, input logic [13:0] ad, input logic f,
                     input logic [6:0] sp, input logic xh);
      u_dac_station.pkt(lf, ad, f, 1'b1, sp, h);
      chk(h, xh);
   endtask : go
   task automatic end_sim();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim
   // Test sequence
   initial begin
      i_nrst = 1'b0;
      repeat (3) @(negedge i_clock);
      i_nrst = 1'b1;
      acc(1'b0, 1'b1, DAC_CV_SHORT_ADDR, 8'h00, 1'b0, DAC_RST_SHORT);
      acc(1'b0, 1'b1, DAC_CV_LONG_HI, 8'h00, 1'b0, DAC_RST_LONG_HI);
      chk(mode, DAC_MODE_14);
      chk(dir, 1'b1);
      $display("test reset done");
      foreach (cfgs[i]) begin
         acc(1'b1, 1'b0, DAC_CV_CONFIG, cfgs[i], 1'b0, 8'h00);
         acc(1'b0, 1'b1, DAC_CV_CONFIG, 8'h00, 1'b0, cfgs[i] & DAC_CFG_MASK);
         chk(ten, cfgs[i][4]);
         chk(lsel, cfgs[i][5]);
         chk(mode, cfgs[i][1] ? DAC_MODE_28 : DAC_MODE_14);
      end
      acc(1'b1, 1'b0, DAC_CV_TABLE_SEL, 8'hff, 1'b0, 8'h00);
      acc(1'b0, 1'b1, DAC_CV_TABLE_SEL, 8'h00, 1'b0, 8'hff);
      chk(tsel, 8'hff);
      $display("test config done");
      acc(1'b1, 1'b1, DAC_CV_SHORT_ADDR, 8'h00, 1'b1, 8'h00);
      acc(1'b1, 1'b1, DAC_CV_SHORT_ADDR, 8'h80, 1'b1, 8'h00);
      acc(1'b1, 1'b1, DAC_CV_SHORT_ADDR, 8'h7f, 1'b0, 8'h00);
      acc(1'b1, 1'b0, DAC_CV_SHORT_ADDR, 8'h05, 1'b1, 8'h00);
      acc(1'b0, 1'b1, DAC_CV_SHORT_ADDR, 8'h00, 1'b0, 8'h7f);
      acc(1'b1, 1'b0, DAC_CV_LONG_HI, 8'hc5, 1'b1, 8'h00);
      acc(1'b1, 1'b0, DAC_CV_LONG_LO, 8'h05, 1'b1, 8'h00);
      acc(1'b0, 1'b1, DAC_CV_LONG_HI, 8'h00, 1'b0, DAC_RST_LONG_HI);
      $display("test short done");
      acc(1'b1, 1'b1, DAC_CV_CONFIG, 8'h03, 1'b0, 8'h00);
      go(1'b0, 14'h007f, 1'b0, 7'h28, 1'b1);
      chk(step, DAC_STEPS_28);
      chk(dir, 1'b0);
      go(1'b0, 14'h007f, 1'b1, 7'h64, 1'b1);
      chk(step, 7'h64);
      chk(mode, DAC_MODE_128);
      acc(1'b1, 1'b1, DAC_CV_CONFIG, 8'h00, 1'b0, 8'h00);
      go(1'b0, 14'h007f, 1'b0, 7'h28, 1'b1);
      chk(step, DAC_STEPS_14);
      chk(dir, 1'b1);
      $display("test packets done");
      acc(1'b1, 1'b1, DAC_CV_LONG_LO, 8'h10, 1'b1, 8'h00);
      acc(1'b1, 1'b1, DAC_CV_LONG_HI, 8'hc4, 1'b0, 8'h00);
      chk(pend, 1'b1);
      acc(1'b1, 1'b1, DAC_CV_SHORT_ADDR, 8'h7f, 1'b0, 8'h00);
      acc(1'b1, 1'b1, DAC_CV_LONG_LO, 8'hd2, 1'b1, 8'h00);
      acc(1'b1, 1'b1, DAC_CV_LONG_HI, 8'he7, 1'b0, 8'h00);
      acc(1'b1, 1'b1, DAC_CV_LONG_LO, 8'h10, 1'b1, 8'h00);
      u_dac_station.long_addr(14'h04d2, e, h);
      chk({e, h, pend}, 3'h0);
      acc(1'b0, 1'b1, DAC_CV_LONG_LO, 8'h00, 1'b0, 8'hd2);
      acc(1'b1, 1'b1, DAC_CV_CONFIG, 8'h20, 1'b0, 8'h00);
      go(1'b1, 14'h04d2, 1'b0, 7'h05, 1'b1);
      go(1'b0, 14'h007f, 1'b0, 7'h05, 1'b0);
      acc(1'b0, 1'b1, 10'h3ff, 8'h00, 1'b1, 8'h00);
      $display("test long done");
      end_sim();
   end
endmodule : dac_core_tb
bind dac_core dac_core_props u_props (.i_clock(i_clock), .i_nrst(i_nrst), .i_cv_req(i_cv_req),
   .o_cv_err(o_cv_err), .o_cv_rdata(o_cv_rdata), .o_long_pending(o_long_pending),
   .o_pkt_hit(o_pkt_hit), .o_speed_step(o_speed_step), .o_step_mode(o_step_mode),
   .o_table_en(o_table_en), .o_long_sel(o_long_sel));

// >>> verification/dac_station.sv
`timescale 1ns/100ps
module dac_station
   import dac_pkg::*;
(
   input  wire logic       i_clock,
   input  wire logic       i_cv_ack,
   input  wire logic       i_cv_err,
   input  wire logic [7:0] i_cv_rdata,
   input  wire logic       i_pkt_hit,
   output dac_cv_req_t     o_cv_req,
   output dac_pkt_t        o_pkt
);
   // Idle at time zero
   initial o_cv_req = '0;
   initial o_pkt = '0;
   // One access; answer taken while it stands, then fields scrambled
   task automatic cv(input logic w, s, input logic [9:0] n, input logic [7:0] d,
                     output logic a, e, output logic [7:0] r);
      @(negedge i_clock);
      o_cv_req = '{1'b1, w, s, n, d};
      @(negedge i_clock);
      a = i_cv_ack;
      e = i_cv_err;
      r = i_cv_rdata;
      o_cv_req = '{1'b0, ~w, ~s, ~n, ~d};
   endtask : cv
   // Marked high byte, then low byte
   task automatic long_addr(input logic [13:0] v, output logic e1, e2);
      logic       a;
      logic [7:0] r;
      cv(1'b1, 1'b1, DAC_CV_LONG_HI, {DAC_LONG_MARK, v[13:8]}, a, e1, r);
      cv(1'b1, 1'b1, DAC_CV_LONG_LO, v[7:0], a, e2, r);
   endtask : long_addr
   // Speed packet; hit sampled while it stands
   task automatic pkt(input logic lf, input logic [13:0] ad, input logic f, fw,
                      input logic [6:0] sp, output logic h);
      @(negedge i_clock);
      o_pkt = '{1'b1, lf, ad, f, fw, sp};
      @(negedge i_clock);
      h = i_pkt_hit;
      o_pkt = '{1'b0, ~lf, ~ad, ~f, ~fw, ~sp};
   endtask : pkt
endmodule : dac_station
